/* hdl/lpt_target.sv */
// Bus peripheral target: cycle decode, SYNC, turnaround, DMA request, receive FIFO.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Only one-byte I/O read/write and DMA read/write are accepted; others ignored.
// - Frame seen asserted releases the data lines next clock and restarts decode.
// - I/O bytes are separated by at least one wait state.
// - DMA read brings host data in, DMA write sends data out; 1, 2 or 4 bytes.
// - On reads the target drives SYNC as soon as the cycle is its own.
// - Stall with 0101 or 0110 until ready, never mixing both in one cycle.
// - Ready code 0000 is followed on the next clock by data, or by the 1111 turnaround when the host sent the data.
// - DMA wait states always use the short-wait code.
// - I/O wait states always use the long-wait code.
// - A valid SYNC code appears within three clocks of the sync phase start.
// - Short-wait SYNC reaches a final code within eight SYNC clocks, nine on later bytes of a multi-byte DMA write.
// - Long-wait SYNC has its own timeout that forces completion.
// - Errors use code 1010; on I/O reads and DMA writes the two data nibbles still follow.
// - An error SYNC ends a multi-byte DMA cycle; later bytes are not moved.
// - Only start code 0000 opens I/O and DMA cycles.
// - In bus reset the target ignores frame, floats data, holds request high.
// - Last driver drives 1111 for one turnaround clock, then nobody drives.
// - Power-down notice makes the target quiesce its bus interface.
// - Wait states: I/O read 3, I/O write 2, DMA read 3, DMA write 4 (5 on later bytes of a multi-byte DMA write).
// - Stalled I/O repeats long-wait up to 330 times before forcing completion.

////////////////////////////////////////////////////////////////////////////////
// Small synchronous FIFO; the full flag stalls the bus through the SYNC phase.
module lpt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lpt_fifo_s;
  lpt_fifo_s st_ff;
  lpt_fifo_s nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Push and pop only when the matching side is ready, so full and empty stay honest.
  always_comb
  begin
    push = in_valid && (st_ff.cnt != (AW+1)'(DEPTH));
    pop = out_ready && (st_ff.cnt != '0);
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.wp = (st_ff.wp == AW'(DEPTH-1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop)
    begin
      nxt_st.rp = (st_ff.rp == AW'(DEPTH-1)) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Storage has no reset; only the pointers and the count decide what is valid.
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[st_ff.wp] <= in_data;
    end
  end

  assign in_ready = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data = mem[st_ff.rp];
endmodule : lpt_fifo

////////////////////////////////////////////////////////////////////////////////
// Target top. Bus pins are sampled through two flops; protocol steps on bus clock rises.
module lpt_target #(
  parameter logic [15:0] IO_BASE = 16'h0000,
  parameter logic [15:0] IO_MASK = 16'hfff8,
  parameter logic [7:0] DMA_CH_EN = 8'h0f,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic lpc_clk_pin,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe_n,
  input wire logic lframe_n,
  input wire logic bus_reset_low,
  input wire logic bus_power_down_notice,
  output logic ldrq_n,
  output logic power_down_ready,
  input wire logic [3:0] dma_req,
  output logic rd_req,
  output logic [15:0] rd_addr,
  input wire logic rd_ack,
  input wire logic [7:0] rd_data,
  input wire logic rd_err,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_taken,
  output logic rx_valid,
  output logic [24:0] rx_data,
  input wire logic rx_ready
);
  typedef struct packed {
    lpt_pkg::lpt_state_e st;
    logic [3:0] ctype;
    logic [15:0] addr;
    logic [7:0] data;
    logic [2:0] ch;
    logic [2:0] nbytes;
    logic [2:0] bcnt;
    logic [8:0] wcnt;
    logic [1:0] nib;
    logic fin;
    logic err;
    logic done;
    logic [3:0] lad_s1;
    logic [3:0] lad_s2;
    logic fr_s1;
    logic fr_s2;
    logic rst_s1;
    logic rst_s2;
    logic pd_s1;
    logic pd_s2;
    logic ck_s1;
    logic ck_s2;
    logic ck_d;
    logic [3:0] lad_out;
    logic lad_oe_n;
    logic ldrq_n;
    logic [4:0] rq_sh;
    logic [2:0] rq_cnt;
    logic [3:0] rq_sent;
    logic rd_req;
    logic tx_taken;
    logic pd_ready;
  } lpt_target_s;
  lpt_target_s st_ff;
  lpt_target_s nxt_st;
  logic tick;
  logic is_io;
  logic host_sends;
  logic ok;
  logic more;
  logic do_sync;
  logic push;
  logic fifo_in_ready;
  logic [8:0] minw;
  logic [24:0] push_word;

  // Decode of the latched cycle type, shared by the sequencer and the checks.
  always_comb
  begin
    tick = st_ff.ck_s2 && !st_ff.ck_d;
    is_io = !st_ff.ctype[3];
    host_sends = is_io ? st_ff.ctype[1] : !st_ff.ctype[1];
    more = (st_ff.bcnt + 3'h1) < st_ff.nbytes;
    unique case (st_ff.ctype[3:1])
      lpt_pkg::CT_IO_RD: minw = lpt_pkg::WAIT_IO_RD;
      lpt_pkg::CT_IO_WR: minw = lpt_pkg::WAIT_IO_WR;
      lpt_pkg::CT_DMA_RD: minw = lpt_pkg::WAIT_DMA_RD;
      default: minw = lpt_pkg::WAIT_DMA_WR;
    endcase
    // Host data waits on FIFO room; target data waits on the user's answer.
    ok = host_sends ? fifo_in_ready : st_ff.done;
    push_word = {st_ff.ctype[3], st_ff.addr, st_ff.data};
  end

  // Sequencer. The value chosen on a bus clock rise is driven for the following bus clock.
  always_comb
  begin
    nxt_st = st_ff;
    do_sync = 1'b0;
    push = 1'b0;
    nxt_st.lad_s1 = lad_in;
    nxt_st.lad_s2 = st_ff.lad_s1;
    nxt_st.fr_s1 = lframe_n;
    nxt_st.fr_s2 = st_ff.fr_s1;
    nxt_st.rst_s1 = bus_reset_low;
    nxt_st.rst_s2 = st_ff.rst_s1;
    nxt_st.pd_s1 = bus_power_down_notice;
    nxt_st.pd_s2 = st_ff.pd_s1;
    nxt_st.ck_s1 = lpc_clk_pin;
    nxt_st.ck_s2 = st_ff.ck_s1;
    nxt_st.ck_d = st_ff.ck_s2;
    nxt_st.rd_req = 1'b0;
    nxt_st.tx_taken = 1'b0;
    nxt_st.pd_ready = !st_ff.pd_s2;
    // Read answers are caught whenever they come; a DMA byte is taken only during SYNC.
    if (rd_ack && is_io && !st_ff.done)
    begin
      nxt_st.done = 1'b1;
      nxt_st.data = rd_data;
      nxt_st.err = rd_err;
    end
    if (tx_valid && !is_io && !host_sends && !st_ff.done && st_ff.st == lpt_pkg::ST_SYNC)
    begin
      nxt_st.done = 1'b1;
      nxt_st.data = tx_data;
      nxt_st.tx_taken = 1'b1;
    end
    if (!st_ff.rst_s2 || !st_ff.pd_s2)
    begin
      // Bus reset or power-down: frame ignored, lines floated, request idle high.
      nxt_st.st = lpt_pkg::ST_IDLE;
      nxt_st.lad_oe_n = 1'b1;
      nxt_st.ldrq_n = 1'b1;
      nxt_st.rq_cnt = '0;
      nxt_st.rq_sent = '0;
    end
    else if (tick)
    begin
      nxt_st.lad_oe_n = 1'b1;
      if (!st_ff.fr_s2)
      begin
        // Frame asserted: let go of the lines and look for the start code.
        nxt_st.st = (st_ff.lad_s2 == lpt_pkg::START_IO_DMA) ? lpt_pkg::ST_CYC
                                                           : lpt_pkg::ST_IDLE;
        nxt_st.nib = '0;
        nxt_st.bcnt = '0;
        nxt_st.done = 1'b0;
        nxt_st.err = 1'b0;
        nxt_st.addr = '0;
      end
      else
      begin
        unique case (st_ff.st)
          lpt_pkg::ST_IDLE: nxt_st.st = lpt_pkg::ST_IDLE;
          lpt_pkg::ST_CYC:
          begin
            nxt_st.ctype = st_ff.lad_s2;
            nxt_st.nbytes = 3'h1;
            unique case (st_ff.lad_s2[3:1])
              lpt_pkg::CT_IO_RD, lpt_pkg::CT_IO_WR: nxt_st.st = lpt_pkg::ST_ADDR;
              lpt_pkg::CT_DMA_RD, lpt_pkg::CT_DMA_WR: nxt_st.st = lpt_pkg::ST_CHAN;
              default: nxt_st.st = lpt_pkg::ST_IDLE;
            endcase
          end
          lpt_pkg::ST_ADDR:
          begin
            nxt_st.addr = {st_ff.addr[11:0], st_ff.lad_s2};
            nxt_st.nib = st_ff.nib + 2'h1;
            if (st_ff.nib == lpt_pkg::ADDR_LAST_NIB)
            begin
              nxt_st.nib = '0;
              if (({st_ff.addr[11:0], st_ff.lad_s2} & IO_MASK) != IO_BASE)
              begin
                nxt_st.st = lpt_pkg::ST_IDLE;
              end
              else
              begin
                nxt_st.st = host_sends ? lpt_pkg::ST_HDATA : lpt_pkg::ST_TAR1;
              end
            end
          end
          lpt_pkg::ST_CHAN:
          begin
            nxt_st.ch = st_ff.lad_s2[2:0];
            nxt_st.addr = {13'h0000, st_ff.lad_s2[2:0]};
            nxt_st.st = DMA_CH_EN[st_ff.lad_s2[2:0]] ? lpt_pkg::ST_SIZE : lpt_pkg::ST_IDLE;
          end
          lpt_pkg::ST_SIZE:
          begin
            unique case (st_ff.lad_s2[1:0])
              lpt_pkg::SIZE_1: nxt_st.nbytes = 3'h1;
              lpt_pkg::SIZE_2: nxt_st.nbytes = 3'h2;
              lpt_pkg::SIZE_4: nxt_st.nbytes = 3'h4;
              default: nxt_st.nbytes = 3'h0;
            endcase
            if (st_ff.lad_s2[1:0] == 2'h2)
            begin
              nxt_st.st = lpt_pkg::ST_IDLE;
            end
            else
            begin
              nxt_st.st = host_sends ? lpt_pkg::ST_HDATA : lpt_pkg::ST_TAR1;
            end
          end
          lpt_pkg::ST_HDATA:
          begin
            // Low nibble first.
            if (st_ff.nib[0])
            begin
              nxt_st.data[7:4] = st_ff.lad_s2;
              nxt_st.st = lpt_pkg::ST_TAR1;
            end
            else
            begin
              nxt_st.data[3:0] = st_ff.lad_s2;
            end
            nxt_st.nib = {1'b0, !st_ff.nib[0]};
          end
          lpt_pkg::ST_TAR1:
          begin
            nxt_st.st = lpt_pkg::ST_TAR2;
            nxt_st.rd_req = is_io && !host_sends;
            // Clear the wait count here, so each byte's SYNC counts from zero.
            nxt_st.wcnt = '0;
            nxt_st.fin = 1'b0;
          end
          lpt_pkg::ST_TAR2: do_sync = 1'b1;
          lpt_pkg::ST_SYNC:
          begin
            if (!st_ff.fin)
            begin
              do_sync = 1'b1;
            end
            else if (!host_sends)
            begin
              // Data follows the final code at once, even after an error.
              nxt_st.st = lpt_pkg::ST_TDATA;
              nxt_st.nib = '0;
              nxt_st.lad_out = st_ff.data[3:0];
              nxt_st.lad_oe_n = 1'b0;
            end
            else
            begin
              nxt_st.st = lpt_pkg::ST_BTAR1;
              nxt_st.lad_out = lpt_pkg::LAD_HIGH;
              nxt_st.lad_oe_n = 1'b0;
            end
          end
          lpt_pkg::ST_TDATA:
          begin
            if (!st_ff.nib[0])
            begin
              nxt_st.nib = 2'h1;
              nxt_st.lad_out = st_ff.data[7:4];
              nxt_st.lad_oe_n = 1'b0;
            end
            else if (!is_io && more && !st_ff.err)
            begin
              // Next DMA byte gets its own wait states.
              nxt_st.bcnt = st_ff.bcnt + 3'h1;
              nxt_st.done = 1'b0;
              nxt_st.wcnt = '0;
              nxt_st.fin = 1'b0;
              nxt_st.st = lpt_pkg::ST_SYNC;
              nxt_st.lad_out = lpt_pkg::SYNC_SHORT;
              nxt_st.lad_oe_n = 1'b0;
            end
            else
            begin
              nxt_st.st = lpt_pkg::ST_BTAR1;
              nxt_st.lad_out = lpt_pkg::LAD_HIGH;
              nxt_st.lad_oe_n = 1'b0;
            end
          end
          lpt_pkg::ST_BTAR1: nxt_st.st = lpt_pkg::ST_BTAR2;
          lpt_pkg::ST_BTAR2:
          begin
            // An error ends a multi-byte DMA read here.
            if (!is_io && host_sends && more && !st_ff.err)
            begin
              nxt_st.bcnt = st_ff.bcnt + 3'h1;
              nxt_st.nib = '0;
              nxt_st.st = lpt_pkg::ST_HDATA;
            end
            else
            begin
              nxt_st.st = lpt_pkg::ST_IDLE;
            end
          end
        endcase
      end
      if (do_sync)
      begin
        nxt_st.st = lpt_pkg::ST_SYNC;
        nxt_st.lad_oe_n = 1'b0;
        // The wait code is fixed by cycle kind, so the two never mix.
        if ((st_ff.wcnt < minw || !ok) && (is_io ? st_ff.wcnt < lpt_pkg::LONG_SYNC_MAX
                                                 : st_ff.wcnt < lpt_pkg::SHORT_SYNC_MAX - 9'h001))
        begin
          nxt_st.lad_out = is_io ? lpt_pkg::SYNC_LONG : lpt_pkg::SYNC_SHORT;
          nxt_st.wcnt = st_ff.wcnt + 9'h001;
        end
        else
        begin
          // Timeout or a failed access forces completion with the error code.
          nxt_st.fin = 1'b1;
          nxt_st.err = st_ff.err || !ok;
          nxt_st.lad_out = (ok && !st_ff.err) ? lpt_pkg::SYNC_READY : lpt_pkg::SYNC_ERROR;
          push = ok && host_sends && !st_ff.err;
        end
      end
      // Serial DMA request: start 0, channel msb first, active bit, then idle high.
      if (st_ff.rq_cnt != '0)
      begin
        nxt_st.ldrq_n = st_ff.rq_sh[4];
        nxt_st.rq_sh = {st_ff.rq_sh[3:0], 1'b1};
        nxt_st.rq_cnt = st_ff.rq_cnt - 3'h1;
      end
      else
      begin
        nxt_st.ldrq_n = 1'b1;
        for (int i = 3; i >= 0; i--)
        begin
          if (dma_req[i] != st_ff.rq_sent[i])
          begin
            // Channel msb is always zero, since only four channels are served.
            nxt_st.rq_sh = {1'b0, 1'b0, 2'(i), dma_req[i]};
            nxt_st.rq_cnt = lpt_pkg::LDRQ_FRAME_LEN;
            nxt_st.rq_sent = st_ff.rq_sent;
            nxt_st.rq_sent[i] = dma_req[i];
          end
        end
      end
    end
  end

  // State register; lines float and the request stays idle from reset onward.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.lad_oe_n <= 1'b1;
      st_ff.ldrq_n <= 1'b1;
      st_ff.lad_out <= lpt_pkg::LAD_HIGH;
      // Frame and notice flops wake at their idle level, so no false event follows reset.
      st_ff.fr_s1 <= 1'b1;
      st_ff.fr_s2 <= 1'b1;
      st_ff.pd_s1 <= 1'b1;
      st_ff.pd_s2 <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Received bytes, tagged with kind and address, wait here for the internal functions.
  lpt_fifo #(.WIDTH(25), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(push),
    .in_data(push_word),
    .in_ready(fifo_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  assign lad_out = st_ff.lad_out;
  assign lad_oe_n = st_ff.lad_oe_n;
  assign ldrq_n = st_ff.ldrq_n;
  assign power_down_ready = st_ff.pd_ready;
  assign rd_req = st_ff.rd_req;
  assign rd_addr = st_ff.addr;
  assign tx_taken = st_ff.tx_taken;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the bus behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_frame_release: assert property (tick && !st_ff.fr_s2 && st_ff.rst_s2 && st_ff.pd_s2 |=> lad_oe_n)
    else $error("Lines still driven after frame asserted.");
  a_reset_float: assert property (!st_ff.rst_s2 |=> lad_oe_n && ldrq_n)
    else $error("Bus driven during bus reset.");
  a_io_wait_long: assert property (st_ff.st == lpt_pkg::ST_SYNC && !st_ff.fin && is_io |-> lad_out == lpt_pkg::SYNC_LONG)
    else $error("I/O wait state not long-wait.");
  a_dma_wait_short: assert property (st_ff.st == lpt_pkg::ST_SYNC && !st_ff.fin && !is_io |-> lad_out == lpt_pkg::SYNC_SHORT)
    else $error("DMA wait state not short-wait.");
  a_dma_sync_bound: assert property (st_ff.st == lpt_pkg::ST_SYNC && !is_io |-> st_ff.wcnt < lpt_pkg::SHORT_SYNC_MAX)
    else $error("Short-wait SYNC ran past eight clocks.");
  a_io_timeout_cap: assert property (st_ff.st == lpt_pkg::ST_SYNC && is_io |-> st_ff.wcnt <= lpt_pkg::LONG_SYNC_MAX)
    else $error("Long-wait SYNC ran past the timeout.");
  a_ready_min_wait: assert property (st_ff.st == lpt_pkg::ST_SYNC && st_ff.fin && lad_out == lpt_pkg::SYNC_READY |-> st_ff.wcnt >= minw)
    else $error("Ready code before the minimum wait states.");
  a_bad_type_drop: assert property (tick && st_ff.st == lpt_pkg::ST_CYC && st_ff.fr_s2 && st_ff.rst_s2 && st_ff.pd_s2 && st_ff.lad_s2[2] |=> st_ff.st == lpt_pkg::ST_IDLE)
    else $error("Unsupported cycle type not ignored.");
  a_error_data_next: assert property (tick && st_ff.st == lpt_pkg::ST_SYNC && st_ff.fin && st_ff.err && !host_sends && st_ff.fr_s2 && st_ff.rst_s2 && st_ff.pd_s2 |=> st_ff.st == lpt_pkg::ST_TDATA && !lad_oe_n)
    else $error("Data nibbles missing after error SYNC.");
  a_tar_high: assert property (st_ff.st == lpt_pkg::ST_BTAR1 |-> lad_out == lpt_pkg::LAD_HIGH && !lad_oe_n)
    else $error("First turnaround clock not driven high.");

  c_io_read_done: cover property (st_ff.st == lpt_pkg::ST_TDATA && is_io && !st_ff.err);
  c_dma_multi_byte: cover property (st_ff.st == lpt_pkg::ST_SYNC && !is_io && st_ff.bcnt == 3'h3);
  c_error_sync: cover property (st_ff.st == lpt_pkg::ST_SYNC && lad_out == lpt_pkg::SYNC_ERROR);
endmodule : lpt_target
`default_nettype wire

/* hdl/lpt_pkg.sv */
// Constants for the low-pin-count bus peripheral target.
package lpt_pkg;
  // Codes driven or decoded on the four address/data lines.
  localparam logic [3:0] START_IO_DMA = 4'h0;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] SYNC_SHORT = 4'h5;
  localparam logic [3:0] SYNC_LONG = 4'h6;
  localparam logic [3:0] SYNC_ERROR = 4'ha;
  localparam logic [3:0] LAD_HIGH = 4'hf;
  // Cycle type field, bits 3:1 of the nibble.
  localparam logic [2:0] CT_IO_RD = 3'h0;
  localparam logic [2:0] CT_IO_WR = 3'h1;
  localparam logic [2:0] CT_DMA_RD = 3'h4;
  localparam logic [2:0] CT_DMA_WR = 3'h5;
  // Transfer size field of a DMA cycle.
  localparam logic [1:0] SIZE_1 = 2'h0;
  localparam logic [1:0] SIZE_2 = 2'h1;
  localparam logic [1:0] SIZE_4 = 2'h3;
  // Wait states before the ready code, counted in bus clocks.
  localparam logic [8:0] WAIT_IO_RD = 9'h003;
  localparam logic [8:0] WAIT_IO_WR = 9'h002;
  localparam logic [8:0] WAIT_DMA_RD = 9'h003;
  localparam logic [8:0] WAIT_DMA_WR = 9'h004;
  // At most eight SYNC clocks in a short-wait SYNC; the short-wait code fills at most seven of them, except on later DMA write bytes: nine clocks, eight short-wait.
  localparam logic [8:0] SHORT_SYNC_MAX = 9'h008;
  // Long-wait repetitions before a forced completion, about 10 us.
  localparam logic [8:0] LONG_SYNC_MAX = 9'h14a;
  // Index of the last address nibble of an I/O cycle, and clocks in one DMA request frame.
  localparam logic [1:0] ADDR_LAST_NIB = 2'h3;
  localparam logic [2:0] LDRQ_FRAME_LEN = 3'h5;
  // Bus state: what the target is doing during the current bus clock.
  typedef enum logic [3:0] {
    ST_IDLE, ST_CYC, ST_ADDR, ST_CHAN, ST_SIZE, ST_HDATA,
    ST_TAR1, ST_TAR2, ST_SYNC, ST_TDATA, ST_BTAR1, ST_BTAR2
  } lpt_state_e;
endpackage : lpt_pkg

/* tb/lpt_host.sv */
// Host-side bus controller model for the target bench.
`timescale 1ns/10ps
`default_nettype none
module lpt_host (
  output logic bclk,
  output logic lframe_n,
  output wire logic [3:0] lad,
  input wire logic [3:0] lad_out,
  input wire logic lad_oe_n
);
  logic hoe = 1'b0;
  logic [3:0] hv = 4'hf;
  initial bclk = 1'b0;
  initial lframe_n = 1'b1;
  // The bus clock runs free, as the host's clock does.
  always #15 bclk = ~bclk;
  // Pull-ups keep undriven lines high.
  assign lad = !lad_oe_n ? lad_out : (hoe ? hv : 4'hf);
  // Launch one nibble at the falling edge so it is settled at the next rise.
  task automatic put(input logic [3:0] v, input logic oe);
    @(negedge bclk);
    lframe_n <= 1'b1;
    hv <= v;
    hoe <= oe;
  endtask : put
  // One single-byte transfer; the target's answers are returned for judging.
  task automatic cyc(input logic [3:0] st, ty, input logic [15:0] hd, input int nh,
      input bit hw, input logic [7:0] wd, output logic [3:0] code, wc,
      output int waits, output logic [7:0] rd, output logic tok);
    int bad;
    logic [3:0] s;
    code = 4'hf;
    wc = 4'h0;
    waits = 0;
    bad = 0;
    rd = 8'h00;
    tok = 1'b0;
    @(negedge bclk);
    lframe_n <= 1'b0;
    hv <= st;
    hoe <= 1'b1;
    put(ty, 1'b1);
    for (int i = 0; i < nh; i++) put(hd[15-4*i -: 4], 1'b1);
    if (hw) put(wd[3:0], 1'b1);
    if (hw) put(wd[7:4], 1'b1);
    put(4'hf, 1'b1);
    put(4'hf, 1'b0);
    // A mixed wait code is returned as 1111; four bad clocks end the wait.
    while (code == 4'hf && bad < 4)
    begin
      @(posedge bclk);
      s = lad;
      if (s == 4'h5 || s == 4'h6)
      begin
        wc = (waits == 0 || wc == s) ? s : 4'hf;
        waits++;
      end
      else if (s == 4'h0 || s == 4'h9 || s == 4'ha) code = s;
      else bad++;
    end
    if (code != 4'hf)
    begin
      if (!hw) @(posedge bclk) rd[3:0] = lad;
      if (!hw) @(posedge bclk) rd[7:4] = lad;
      @(posedge bclk) tok = (lad == 4'hf) && !lad_oe_n;
      @(posedge bclk) tok = tok && lad_oe_n;
    end
  endtask : cyc
endmodule : lpt_host
`default_nettype wire

/* tb/lpt_target_tb.sv */
// Self-checking bench for the bus peripheral target.
`timescale 1ns/10ps
`default_nettype none
module lpt_target_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic bus_reset_low = 1'b0;
  logic pd_n = 1'b1;
  logic [3:0] dma_req = 4'h0;
  logic rd_ack = 1'b0, rd_err = 1'b0, err_mode = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
  logic mute = 1'b0;
  logic [15:0] ra = 16'h0000;
  logic [7:0] rd_data = 8'h00, rd_val = 8'h00, tx_data = 8'h00, rdv;
  wire logic bclk, lframe_n, lad_oe_n, ldrq_n, pdr, rd_req, tx_taken, rx_valid;
  wire logic [3:0] lad, lad_out;
  wire logic [24:0] rx_data;
  wire logic [15:0] rd_addr;
  logic [3:0] code, wc;
  logic tok;
  int waits, miscompares = 0, n_compared = 0, cycles = 0;
  always #2.5 clock = ~clock;
  lpt_target dut_u (.clock(clock), .rst(rst), .lpc_clk_pin(bclk), .lad_in(lad),
    .lad_out(lad_out), .lad_oe_n(lad_oe_n), .lframe_n(lframe_n),
    .bus_reset_low(bus_reset_low), .bus_power_down_notice(pd_n), .ldrq_n(ldrq_n),
    .power_down_ready(pdr), .dma_req(dma_req), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ack(rd_ack), .rd_data(rd_data), .rd_err(rd_err), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_taken(tx_taken), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready));
  lpt_host host_u (.bclk(bclk), .lframe_n(lframe_n), .lad(lad), .lad_out(lad_out),
    .lad_oe_n(lad_oe_n));
  // Answer reads one clock after the request unless muted, note the address asked for,
  // retire sent bytes, and cut a hang short.
  always @(posedge clock)
  begin
    rd_ack <= rd_req & !mute;
    if (rd_req) ra <= rd_addr;
    rd_data <= rd_val;
    rd_err <= rd_req & err_mode;
    if (tx_taken) tx_valid <= 1'b0;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      miscompares++;
      conclude();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // A code of 1111 means the target must not claim the cycle.
  task automatic run(input logic [3:0] st, ty, input logic [15:0] hd, input int nh,
      input bit hw, input logic [7:0] wd, input logic [3:0] ec, ew, input int en);
    host_u.cyc(st, ty, hd, nh, hw, wd, code, wc, waits, rdv, tok);
    cmp(32'(code), 32'(ec));
    if (ec != 4'hf) cmp(32'(wc), 32'(ew));
    if (ec != 4'hf) cmp(32'(tok), 32'h1);
    if (en >= 0) cmp(32'(waits), 32'(en));
  endtask : run
  // Pop the queue head once it shows; the wait is bounded.
  task automatic pop(input logic [24:0] exp, input logic [24:0] mask);
    for (int n = 0; n < 60 && rx_valid !== 1'b1; n++) @(negedge clock);
    cmp(32'(rx_data & mask), 32'(exp));
    @(posedge clock) rx_ready <= 1'b1;
    @(posedge clock) rx_ready <= 1'b0;
  endtask : pop
  task automatic t_io;
    run(4'h0, {lpt_pkg::CT_IO_WR, 1'b0}, 16'h0003, 4, 1, 8'h5a, 4'h0, 4'h6, 2);
    pop({1'b0, 16'h0003, 8'h5a}, 25'h1ffffff);
    @(posedge clock) rd_val <= 8'hc3;
    run(4'h0, {lpt_pkg::CT_IO_RD, 1'b0}, 16'h0005, 4, 0, 8'h00, 4'h0, 4'h6, 3);
    cmp(32'(rdv), 32'hc3);
    cmp(32'(ra), 32'h0005);
    $display("io transfers done");
  endtask : t_io
  // A failed read still returns two data nibbles after the error code.
  // A read that is never answered runs the long-wait limit out and then errors.
  task automatic t_error;
    @(posedge clock) err_mode <= 1'b1;
    run(4'h0, {lpt_pkg::CT_IO_RD, 1'b0}, 16'h0002, 4, 0, 8'h00, 4'ha, 4'h6, -1);
    @(posedge clock) err_mode <= 1'b0;
    mute <= 1'b1;
    run(4'h0, {lpt_pkg::CT_IO_RD, 1'b0}, 16'h0004, 4, 0, 8'h00, 4'ha, 4'h6, 330);
    @(posedge clock) mute <= 1'b0;
    $display("io error done");
  endtask : t_error
  // Foreign port, wrong start code and unsupported type are all left alone.
  task automatic t_ignored;
    run(4'h0, {lpt_pkg::CT_IO_RD, 1'b0}, 16'h0100, 4, 0, 8'h00, 4'hf, 4'h0, -1);
    run(4'h3, {lpt_pkg::CT_IO_WR, 1'b0}, 16'h0001, 4, 1, 8'h11, 4'hf, 4'h0, -1);
    run(4'h0, 4'h4, 16'h0001, 4, 0, 8'h00, 4'hf, 4'h0, -1);
    $display("ignored cycles done");
  endtask : t_ignored
  task automatic t_dma;
    run(4'h0, {lpt_pkg::CT_DMA_RD, 1'b0}, {4'h1, 2'b00, lpt_pkg::SIZE_1, 8'h00}, 2, 1,
        8'h7e, 4'h0, 4'h5, 3);
    pop({1'b1, 16'h0001, 8'h7e}, 25'h1ffffff);
    @(posedge clock) tx_data <= 8'h96;
    tx_valid <= 1'b1;
    run(4'h0, {lpt_pkg::CT_DMA_WR, 1'b0}, {4'h2, 2'b00, lpt_pkg::SIZE_1, 8'h00}, 2, 0,
        8'h00, 4'h0, 4'h5, 4);
    cmp(32'(rdv), 32'h96);
    // No byte offered: seven short waits, then the error code ends the eighth SYNC clock.
    run(4'h0, {lpt_pkg::CT_DMA_WR, 1'b0}, {4'h2, 2'b00, lpt_pkg::SIZE_1, 8'h00}, 2, 0,
        8'h00, 4'ha, 4'h5, 7);
    $display("dma transfers done");
  endtask : t_dma
  // A request on channel 2 goes out as start, channel bits, active, then idle.
  task automatic t_request;
    logic [5:0] seq;
    @(posedge clock) dma_req <= 4'h4;
    for (int n = 0; n < 300 && ldrq_n !== 1'b0; n++) @(negedge clock);
    for (int i = 5; i >= 0; i--) @(posedge bclk) seq[i] = ldrq_n;
    cmp(32'(seq), 32'h0b);
    $display("dma request done");
  endtask : t_request
  task automatic t_reset;
    @(posedge clock) bus_reset_low <= 1'b0;
    dma_req <= 4'h0;
    repeat (60) @(posedge clock);
    cmp(32'({ldrq_n, lad_oe_n}), 32'h3);
    bus_reset_low <= 1'b1;
    pd_n <= 1'b0;
    repeat (8) @(posedge clock);
    cmp(32'(pdr), 32'h1);
    pd_n <= 1'b1;
    $display("reset and power-down done");
  endtask : t_reset
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    bus_reset_low <= 1'b1;
    repeat (20) @(posedge clock);
    t_io();
    t_error();
    t_ignored();
    t_dma();
    t_request();
    t_reset();
    conclude();
  end
endmodule : lpt_target_tb
`default_nettype wire
